// ==== core/eeprom_host.sv ====
// host controller that drives a multiplexed-bus eeprom peripheral through its pins
`default_nettype none
`include "eeprom_host_defines.svh"
// Notes on behaviour
// - Program-fetch low with read and write high reads the array byte.
// - Data read strobe low reads the array; fetch and write strobes stay high.
// - Write: write strobe low, read high, data on bus; captured on rising edge.
// - Host holds write-commit low throughout every write cycle.
// - Host lowers chip select before the address latch strobe falls.
// - Locking and unlocking use only a dedicated six-byte write sequence.
// - With write guard on, host sends three command bytes before the first byte of a page.
module eeprom_host
#(
  parameter logic [19:0] PAGE_WINDOW_CYC = 20'(`PAGE_WINDOW_TIME_US * 1000 / `CLK_PERIOD_NS),
  parameter logic [19:0] PROG_TIMEOUT_CYC = 20'(`PROG_TIME_MS * 1000000 / `CLK_PERIOD_NS)
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire eeprom_host_pkg::op_t req_op,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [`DATA_W-1:0] req_data,
  input wire logic req_last,
  input wire logic req_guard,
  input wire logic abort_commit,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [`DATA_W-1:0] rsp_data,
  output logic ce_n,
  output logic ale,
  output logic program_fetch_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic write_commit_n,
  output logic [`HIGH_W-1:0] addr_high_bits,
  input wire logic [`DATA_W-1:0] mux_addr_data_low_in,
  output logic [`DATA_W-1:0] mux_addr_data_low_out,
  output logic mux_addr_data_low_oe
);
  import eeprom_host_pkg::*;

  state_t state_ff, nxt_state;
  logic [3:0] cnt_ff;
  op_t op_ff;
  logic [`ADDR_W-1:0] addr_ff;
  logic [`DATA_W-1:0] data_ff, rdata_ff;
  logic last_ff, polling_ff, have_prev_ff, prev_bit_ff;
  logic [2:0] seq_ff, seq_len_ff;
  logic [5:0] page_cnt_ff;
  logic [19:0] timer_ff;
  logic phase_end, take, refuse, fits, is_write, in_cmd, poll_done, poll_timeout;
  logic [`ADDR_W+`DATA_W-1:0] cmd;
  logic [`ADDR_W-1:0] cur_addr;
  logic [`DATA_W-1:0] cur_data;

  // ----------------------------------------------------------------
  // command table and bus cycle target
  // ----------------------------------------------------------------
  function automatic logic [`ADDR_W+`DATA_W-1:0] cmd_entry(input logic [2:0] idx, input logic lock);
    case (idx)
      3'h0: cmd_entry = {`CMD0_ADDR, `CMD0_DATA};
      3'h1: cmd_entry = {`CMD1_ADDR, `CMD1_DATA};
      3'h2: cmd_entry = lock ? {`CMD2_ADDR, `CMD2_LOCK_DATA} : {`CMD2_ADDR, `CMD2_GUARD_DATA};
      3'h3: cmd_entry = {`CMD3_ADDR, `CMD3_DATA};
      default: cmd_entry = {`CMD4_ADDR, `CMD4_DATA};
    endcase
  endfunction : cmd_entry

  assign is_write = (op_ff == OP_WRITE || op_ff == OP_LOCK) && !polling_ff;
  assign in_cmd = is_write && (seq_ff < seq_len_ff);
  assign cmd = cmd_entry(seq_ff, op_ff == OP_LOCK);
  assign cur_addr = in_cmd ? cmd[`ADDR_W+`DATA_W-1:`DATA_W] : addr_ff;
  assign cur_data = in_cmd ? cmd[`DATA_W-1:0] : data_ff;
  // same A5..A12 row and room left in the page
  assign fits = req_op == OP_WRITE && op_ff == OP_WRITE && req_addr[`ADDR_W-1:`PAGE_LSB] == addr_ff[`ADDR_W-1:`PAGE_LSB]
    && page_cnt_ff < `PAGE_BYTES;
  assign poll_done = polling_ff && have_prev_ff && rdata_ff[`TOGGLE_BIT] == prev_bit_ff;
  assign poll_timeout = polling_ff && timer_ff >= PROG_TIMEOUT_CYC;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    take = 1'b0;
    refuse = 1'b0;
    case (state_ff)
      ST_ADDR: phase_end = cnt_ff == `ADDR_LAST;
      ST_LATCH: phase_end = cnt_ff == `LATCH_LAST;
      ST_STROBE: phase_end = cnt_ff == `STROBE_LAST;
      ST_COMMIT: phase_end = cnt_ff == `COMMIT_LAST;
      default: phase_end = cnt_ff == `RECOVER_LAST;
    endcase
    case (state_ff)
      ST_IDLE:
        if (req_valid && req_ready)
        begin
          take = 1'b1;
          nxt_state = ST_ADDR;
        end
      ST_ADDR: if (phase_end) nxt_state = ST_LATCH;
      ST_LATCH: if (phase_end) nxt_state = ST_STROBE;
      ST_STROBE: if (phase_end) nxt_state = ST_RECOVER;
      ST_RECOVER:
        if (phase_end)
        begin
          if (in_cmd) nxt_state = ST_ADDR;
          else if (is_write) nxt_state = last_ff ? ST_COMMIT : ST_WAIT_PAGE;
          else if (polling_ff) nxt_state = poll_done ? ST_IDLE : ST_POLL_GAP;
          else nxt_state = ST_IDLE;
        end
      ST_WAIT_PAGE:
        if (req_valid && fits)
        begin
          take = 1'b1;
          nxt_state = ST_ADDR;
        end
        else if (req_valid)
        begin
          refuse = 1'b1;
          nxt_state = ST_COMMIT;
        end
        else if (timer_ff >= PAGE_WINDOW_CYC) nxt_state = ST_POLL_GAP;
      ST_COMMIT:
        if (abort_commit) nxt_state = ST_IDLE;
        else if (phase_end) nxt_state = ST_POLL_GAP;
      ST_POLL_GAP:
        if (poll_timeout) nxt_state = ST_IDLE;
        else if (phase_end) nxt_state = ST_ADDR;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff || phase_end) ? 4'h0 : cnt_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // request capture, command sequence and page bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_ff <= OP_FETCH;
      addr_ff <= '0;
      data_ff <= '0;
      last_ff <= 1'b0;
      seq_ff <= 3'h0;
      seq_len_ff <= 3'h0;
      page_cnt_ff <= 6'h0;
    end
    else if (take)
    begin
      op_ff <= req_op;
      addr_ff <= req_op == OP_LOCK ? `LOCK_REG_ADDR : req_addr;
      data_ff <= req_data;
      last_ff <= req_last || req_op == OP_LOCK;
      seq_ff <= 3'h0;
      // guard bytes precede only the first byte of a page
      if (req_op == OP_LOCK) seq_len_ff <= `LOCK_LEN;
      else if (req_op == OP_WRITE && req_guard && state_ff == ST_IDLE) seq_len_ff <= `GUARD_LEN;
      else seq_len_ff <= 3'h0;
      if (state_ff == ST_IDLE) page_cnt_ff <= 6'h0;
    end
    else if (state_ff == ST_RECOVER && phase_end && is_write)
    begin
      if (in_cmd) seq_ff <= seq_ff + 3'h1;
      else page_cnt_ff <= page_cnt_ff + 6'h1;
    end
  end

  // ----------------------------------------------------------------
  // page window and programming timer, toggle polling
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset) timer_ff <= 20'h0;
    else if (state_ff == ST_STROBE && cnt_ff == 4'h0 && is_write) timer_ff <= 20'h0;
    else if (state_ff == ST_COMMIT && nxt_state == ST_POLL_GAP) timer_ff <= 20'h0;
    else if (state_ff == ST_WAIT_PAGE && nxt_state == ST_POLL_GAP) timer_ff <= 20'h0;
    else if (timer_ff != 20'hFFFFF) timer_ff <= timer_ff + 20'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      polling_ff <= 1'b0;
      have_prev_ff <= 1'b0;
      prev_bit_ff <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      if (state_ff == ST_RECOVER && cnt_ff == 4'h0) rdata_ff <= mux_addr_data_low_in;
      if (nxt_state == ST_POLL_GAP && !polling_ff)
      begin
        polling_ff <= 1'b1;
        have_prev_ff <= 1'b0;
      end
      else if (nxt_state == ST_IDLE) polling_ff <= 1'b0;
      if (polling_ff && state_ff == ST_RECOVER && phase_end)
      begin
        have_prev_ff <= 1'b1;
        prev_bit_ff <= rdata_ff[`TOGGLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // user responses
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      req_ready <= nxt_state == ST_IDLE || (nxt_state == ST_WAIT_PAGE && !take);
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      if (state_ff == ST_RECOVER && phase_end && !is_write && !polling_ff)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= rdata_ff;
      end
      else if (refuse || (state_ff == ST_COMMIT && abort_commit) || (state_ff == ST_POLL_GAP && poll_timeout))
      begin
        rsp_valid <= 1'b1;
        rsp_error <= 1'b1;
      end
      else if (state_ff == ST_RECOVER && phase_end && poll_done) rsp_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, one cycle behind the sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ce_n <= 1'b1;
      ale <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      write_commit_n <= 1'b1;
      addr_high_bits <= '0;
      mux_addr_data_low_out <= '0;
      mux_addr_data_low_oe <= 1'b0;
    end
    else
    begin
      // chip select falls with the latch strobe rising, ahead of its fall
      ce_n <= !(state_ff inside {ST_ADDR, ST_LATCH, ST_STROBE, ST_RECOVER});
      ale <= state_ff == ST_ADDR;
      program_fetch_strobe_n <= !(state_ff == ST_STROBE && op_ff == OP_FETCH && !polling_ff);
      rd_n <= !(state_ff == ST_STROBE && (op_ff == OP_READ || polling_ff));
      wr_n <= !(state_ff == ST_STROBE && is_write);
      write_commit_n <= !(is_write && state_ff != ST_IDLE);
      addr_high_bits <= cur_addr[`ADDR_W-1:`DATA_W];
      mux_addr_data_low_out <= state_ff inside {ST_ADDR, ST_LATCH} ? cur_addr[`DATA_W-1:0] : cur_data;
      mux_addr_data_low_oe <= state_ff inside {ST_ADDR, ST_LATCH}
        || (is_write && state_ff inside {ST_STROBE, ST_RECOVER});
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CE_BEFORE_ALE_FALL: assert property ($fell(ale) |-> !ce_n && !$past(ce_n, 2))
    else $error("latch strobe fell without chip select held low");
  AST_ALE_DRIVES_ADDR: assert property (ale |-> mux_addr_data_low_oe ##1 mux_addr_data_low_oe)
    else $error("address not driven around latch strobe fall");
  AST_FETCH_EXCLUSIVE: assert property (!program_fetch_strobe_n |-> rd_n && wr_n && !mux_addr_data_low_oe)
    else $error("fetch strobe overlaps another strobe or bus drive");
  AST_READ_EXCLUSIVE: assert property (!rd_n |-> program_fetch_strobe_n && wr_n && !ce_n)
    else $error("read strobe overlaps another strobe");
  AST_WRITE_DATA_STABLE: assert property (!wr_n && !$past(wr_n) |-> $stable(mux_addr_data_low_out) && rd_n)
    else $error("write data moved while write strobe low");
  AST_WRITE_HOLD: assert property ($rose(wr_n) |-> mux_addr_data_low_oe)
    else $error("bus released at write strobe rise");
  AST_COMMIT_IN_WRITE: assert property (!wr_n |-> !write_commit_n ##1 !write_commit_n)
    else $error("write-commit not low through write cycle");
  AST_STANDBY_RELEASE: assert property (ce_n |-> !mux_addr_data_low_oe && !ale)
    else $error("bus driven while deselected");
  AST_PAGE_LIMIT: assert property (page_cnt_ff <= `PAGE_BYTES)
    else $error("page longer than allowed");
  AST_NO_WRITE_WHILE_POLL: assert property (polling_ff |-> wr_n && !req_ready)
    else $error("write or request accepted during programming");
  AST_GUARD_FIRST: assert property ($fell(wr_n) && seq_len_ff == `GUARD_LEN && seq_ff == 3'h0
    |-> mux_addr_data_low_out == `CMD0_DATA)
    else $error("guarded write did not open with the first command byte");

  COV_FETCH: cover property (!program_fetch_strobe_n ##[1:20] rsp_valid);
  COV_READ: cover property (!rd_n && !polling_ff ##[1:20] rsp_valid);
  COV_PAGE: cover property (state_ff == ST_WAIT_PAGE ##1 take);
  COV_ABORT: cover property (state_ff == ST_COMMIT && abort_commit);
endmodule : eeprom_host
`default_nettype wire

// ==== core/eeprom_host_defines.svh ====
// timing, address and command constants for the eeprom host controller
`ifndef EEPROM_HOST_DEFINES_SVH
`define EEPROM_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define ADDR_W 13
`define DATA_W 8
`define HIGH_W 5
`define TOGGLE_BIT 6
`define PAGE_LSB 5
`define PAGE_BYTES 6'h20
`define GUARD_LEN 3'h3
`define LOCK_LEN 3'h5

// bus phase times (least times, rounded up to whole cycles)
`define ADDR_TIME_NS 20
`define LATCH_TIME_NS 20
`define STROBE_TIME_NS 100
`define RECOVER_TIME_NS 20
`define COMMIT_DELAY_TIME_NS 100
`define ADDR_LAST 4'((`ADDR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1)
`define LATCH_LAST 4'((`LATCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1)
`define STROBE_LAST 4'((`STROBE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1)
`define RECOVER_LAST 4'((`RECOVER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1)
`define COMMIT_LAST 4'((`COMMIT_DELAY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1)

// page byte window (longest, rounded down) and programming time (least, rounded down)
`define PAGE_WINDOW_TIME_US 100
`define PROG_TIME_MS 5

// unlock and lock command bytes: {address, data}
`define CMD0_ADDR 13'h1555
`define CMD0_DATA 8'hAA
`define CMD1_ADDR 13'h0AAA
`define CMD1_DATA 8'h55
`define CMD2_ADDR 13'h1555
`define CMD2_GUARD_DATA 8'hA0
`define CMD2_LOCK_DATA 8'h80
`define CMD3_ADDR 13'h1555
`define CMD3_DATA 8'hAA
`define CMD4_ADDR 13'h0AAA
`define CMD4_DATA 8'h55
`define LOCK_REG_ADDR 13'h1FFF

`endif

// ==== core/eeprom_host_pkg.sv ====
// types shared by the eeprom host controller
`default_nettype none
package eeprom_host_pkg;
  typedef enum logic [1:0]
  {
    OP_FETCH = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2,
    OP_LOCK = 2'h3
  } op_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_LATCH = 3'h3,
    ST_STROBE = 3'h2,
    ST_RECOVER = 3'h6,
    ST_WAIT_PAGE = 3'h7,
    ST_COMMIT = 3'h5,
    ST_POLL_GAP = 3'h4
  } state_t;
endpackage : eeprom_host_pkg
`default_nettype wire

// ==== bench/eeprom_dev_model.sv ====
// behavioural model of the multiplexed-bus eeprom peripheral
`default_nettype none
`include "eeprom_host_defines.svh"
module eeprom_dev_model
#(
  parameter int PROG_NS = 3000
)
(
  input wire logic ce_n,
  input wire logic ale,
  input wire logic program_fetch_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic write_commit_n,
  input wire logic [4:0] addr_high_bits,
  input wire logic [7:0] host_out,
  input wire logic host_oe,
  output logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];
  logic [7:0] lock_reg = 8'h00;
  logic [7:0] last = 8'h00;
  logic [12:0] addr = 13'h0000;
  logic guard_en = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic rd_act;
  logic [7:0] drv;
  logic [20:0] pq [$];
  realtime t_wr = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  function automatic bit hit(int i, logic [12:0] a, logic [7:0] d);
    return i < pq.size() && pq[i] == {a, d};
  endfunction : hit
  // ----------------------------------------
  // bus side
  // ----------------------------------------
  always @(negedge ale) if (!ce_n && host_oe) addr = {addr_high_bits, host_out};
  assign rd_act = !ce_n && wr_n && (rd_n != program_fetch_strobe_n);
  assign drv = busy ? {1'b0, tog, 6'h00} : mem[addr];
  // released bus shows the inverse of the last value seen
  always @(host_oe, host_out, rd_act, drv) if (host_oe) last = host_out; else if (rd_act) last = drv;
  assign bus = host_oe ? host_out : rd_act ? drv : ~last;
  always @(posedge rd_n or posedge program_fetch_strobe_n) if (busy && !ce_n) tog = ~tog;
  // ----------------------------------------
  // write side
  // ----------------------------------------
  always @(posedge wr_n)
  begin
    if (!ce_n && rd_n && !write_commit_n && !busy)
    begin
      pq.push_back({addr, host_out});
      t_wr = $realtime;
    end
  end
  always @(posedge write_commit_n)
  begin
    if (pq.size() > 0 && $realtime - t_wr < `COMMIT_DELAY_TIME_NS) pq.delete();
    else if (pq.size() > 0) program_page();
  end
  task automatic program_page;
    int s;
    s = 0;
    busy = 1'b1;
    if (pq.size() == 6 && hit(0, `CMD0_ADDR, `CMD0_DATA) && hit(1, `CMD1_ADDR, `CMD1_DATA) &&
        hit(2, `CMD2_ADDR, `CMD2_LOCK_DATA) && hit(3, `CMD3_ADDR, `CMD3_DATA) &&
        hit(4, `CMD4_ADDR, `CMD4_DATA) && pq[5][20:8] == `LOCK_REG_ADDR)
      lock_reg = pq[5][7:0];
    else
    begin
      if (hit(0, `CMD0_ADDR, `CMD0_DATA) && hit(1, `CMD1_ADDR, `CMD1_DATA) && hit(2, `CMD2_ADDR, `CMD2_GUARD_DATA))
      begin
        guard_en = 1'b1;
        s = 3;
      end
      else if (guard_en) s = pq.size();
      for (int i = s; i < pq.size(); i++)
        if (!lock_reg[pq[i][20:18]]) mem[pq[i][20:8]] = pq[i][7:0];
    end
    pq.delete();
    #(PROG_NS) busy = 1'b0;
  endtask : program_page
endmodule : eeprom_dev_model
`default_nettype wire

// ==== bench/tb_eeprom_host.sv ====
// self-checking testbench for the eeprom host controller
`default_nettype none
`include "eeprom_host_defines.svh"
module tb_eeprom_host;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  logic clk = 0, reset = 1, req_valid = 0, req_last = 0, req_guard = 0, abort_commit = 0;
  op_t req_op = OP_READ;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0] req_data = 8'h00;
  logic req_ready, rsp_valid, rsp_error, ce_n, ale, fetch_n, rd_n, wr_n, commit_n, oe;
  logic [4:0] high;
  logic [7:0] rsp_data, bus_out, bus_in;
  int miscompares = 0, comparisons = 0, cycles = 0, seed = 32'h576a;
  int ref_mem [8192];
  logic [7:0] lock_mask = 8'h00;
  bit ref_guard = 0;
  always #5 clk = ~clk;
  eeprom_host #(.PAGE_WINDOW_CYC(20'd200), .PROG_TIMEOUT_CYC(20'd2000)) eeprom_host_i (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_last(req_last),
    .req_guard(req_guard), .abort_commit(abort_commit), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data), .ce_n(ce_n), .ale(ale), .program_fetch_strobe_n(fetch_n),
    .rd_n(rd_n), .wr_n(wr_n), .write_commit_n(commit_n), .addr_high_bits(high), .mux_addr_data_low_in(bus_in),
    .mux_addr_data_low_out(bus_out), .mux_addr_data_low_oe(oe));
  eeprom_dev_model eeprom_dev_model_i (.ce_n(ce_n), .ale(ale), .program_fetch_strobe_n(fetch_n), .rd_n(rd_n),
    .wr_n(wr_n), .write_commit_n(commit_n), .addr_high_bits(high), .host_out(bus_out), .host_oe(oe), .bus(bus_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic send(op_t op, logic [12:0] a, logic [7:0] d, logic last, logic g);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_last <= last;
    req_guard <= g;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : send
  task automatic get_rsp(output logic e, output logic [7:0] d);
    do @(posedge clk); while (rsp_valid !== 1'b1);
    e = rsp_error;
    d = rsp_data;
  endtask : get_rsp
  task automatic rd(op_t op, logic [12:0] a);
    logic e;
    logic [7:0] d;
    send(op, a, 8'h00, 1'b1, 1'b0);
    get_rsp(e, d);
    check({7'h00, e}, 8'h00);
    check(d, 8'(ref_mem[a]));
  endtask : rd
  task automatic page(logic [12:0] base, int n, logic g, logic ab);
    logic e;
    logic [7:0] d;
    logic [7:0] dv [$];
    abort_commit <= ab;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      dv.push_back(d);
      send(OP_WRITE, 13'(base + i), d, i == n - 1, g && i == 0);
    end
    get_rsp(e, d);
    abort_commit <= 1'b0;
    check({7'h00, e}, {7'h00, ab});
    if (!ab && (g || !ref_guard))
    begin
      ref_guard |= g;
      for (int i = 0; i < n; i++)
        if (!lock_mask[3'(base[12:10])]) ref_mem[13'(base + i)] = dv[i];
    end
    for (int i = 0; i < n; i += 3) rd(i % 2 ? OP_FETCH : OP_READ, 13'(base + i));
  endtask : page
  task automatic lock(logic [7:0] m);
    logic e;
    logic [7:0] d;
    send(OP_LOCK, 13'h0000, m, 1'b1, 1'b0);
    get_rsp(e, d);
    check({7'h00, e}, 8'h00);
    lock_mask = m;
  endtask : lock
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic e;
    logic [7:0] d;
    foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(OP_FETCH, 13'($random(seed)));
    rd(OP_READ, 13'($random(seed)));
    page(13'h0100, 32, 1'b0, 1'b0);
    page(13'h0800, 2, 1'b0, 1'b1);
    page(13'h0400, 2, 1'b1, 1'b0);
    page(13'h0440, 1, 1'b0, 1'b0);
    lock(8'h04);
    page(13'h0820, 4, 1'b1, 1'b0);
    page(13'h0C20, 4, 1'b1, 1'b0);
    lock(8'h00);
    page(13'h0820, 2, 1'b1, 1'b0);
    send(OP_WRITE, 13'h1000, 8'h3C, 1'b0, 1'b1);
    send(OP_READ, 13'h1000, 8'h00, 1'b1, 1'b0);
    get_rsp(e, d);
    check({7'h00, e}, 8'h01);
    get_rsp(e, d);
    check({7'h00, e}, 8'h00);
    ref_mem[13'h1000] = 8'h3C;
    rd(OP_READ, 13'h1000);
    // a lone non-last byte left to the page window goes to programming by itself
    d = 8'($random(seed));
    send(OP_WRITE, 13'h1040, d, 1'b0, 1'b1);
    ref_mem[13'h1040] = d;
    get_rsp(e, d);
    check({7'h00, e}, 8'h00);
    rd(OP_READ, 13'h1040);
    finish_test();
  end
endmodule : tb_eeprom_host
`default_nettype wire
